// ==== rtl/pulse_pkg.sv ====
// Constants for the two pulse output channels
package pulse_pkg;
    // Register offsets (printed indexes)
    localparam logic [15:0] OFS_CH0_CONTROL = 16'h03d8;
    localparam logic [15:0] OFS_CH0_HIGH = 16'h03d9;
    localparam logic [15:0] OFS_CH0_LOW = 16'h03da;
    localparam logic [15:0] OFS_CH1_CONTROL = 16'h03db;
    localparam logic [15:0] OFS_CH1_HIGH = 16'h03dc;
    localparam logic [15:0] OFS_CH1_LOW = 16'h03dd;
    localparam logic [15:0] OFS_CH_STRIDE = 16'h0003;
    // Control field positions
    localparam int CMD_LSB = 6;
    localparam int CMD_MSB = 8;
    localparam int EN_BIT = 5;
    localparam int PIN_LSB = 0;
    localparam int PIN_MSB = 2;
    localparam int TIME_MSB = 11;
    // Command codes
    localparam logic [2:0] CMD_IDLE = 3'h0;
    localparam logic [2:0] CMD_LOW_A = 3'h4;
    localparam logic [2:0] CMD_ONE_SHOT = 3'h5;
    localparam logic [2:0] CMD_FREE_RUN = 3'h6;
    localparam logic [2:0] CMD_LOW_B = 3'h7;
    // Reset values
    localparam logic [2:0] CMD_RESET = 3'h0;
    localparam logic [2:0] PIN_RESET = 3'h0;
    localparam logic [11:0] TIME_RESET = 12'h001;
    // Tick timing, picoseconds
    localparam int CLK_PERIOD_PS = 40000;
    localparam int TICK_TIME_PS = 266667;
    localparam int ACC_W = 19;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS);
    localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(TICK_TIME_PS);
    // Least clock cycles between ticks
    localparam int TICK_MIN_CYC = TICK_TIME_PS / CLK_PERIOD_PS;
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_SHOT = 3'b010,
        ST_RUN = 3'b100
    } chan_state_t;
endpackage : pulse_pkg

// ==== rtl/dual_pulse_out.sv ====
// Two pulse output channels with their control and period registers
//
// Overview of operation
// - Idle command keeps the pin at its present level, no toggling.
// - Commands 100 and 111 drive the pin low and hold it.
// - One-shot emits one pulse opposite to the previously held level.
// - Free-run alternates high for high count, low for low count.
// - Enable bit gates the channel; clear means no pin driven.
// - Three-bit pin field picks one of eight general pins.
// - High time is high count times one 266.667 ns tick.
// - Low time is low count times the same tick.
// - A second channel with identical registers runs independently.
`timescale 1ns/1ps
module dual_pulse_out
    import pulse_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic [7:0] gp_pin_o,
    output logic [7:0] gp_pin_oe_o
);

    // ==========================================================
    // Registers
    logic [2:0] cmd [2];
    logic en [2];
    logic [2:0] pin [2];
    logic [11:0] high_time [2];
    logic [11:0] low_time [2];
    logic [2:0] next_cmd [2];
    logic next_en [2];
    logic [2:0] next_pin [2];
    logic [11:0] next_high_time [2];
    logic [11:0] next_low_time [2];
    logic ctrl_wr [2];
    logic [15:0] next_rdata;

    function automatic logic [15:0] ch_base(input int c);
        ch_base = OFS_CH0_CONTROL + 16'(c) * OFS_CH_STRIDE;
    endfunction : ch_base

    always_comb begin
        next_rdata = 16'h0000;
        for (int c = 0; c < 2; c++) begin
            next_cmd[c] = cmd[c];
            next_en[c] = en[c];
            next_pin[c] = pin[c];
            next_high_time[c] = high_time[c];
            next_low_time[c] = low_time[c];
            ctrl_wr[c] = reg_wr_i && (reg_addr_i == ch_base(c));
            if (ctrl_wr[c]) begin
                next_cmd[c] = reg_wdata_i[CMD_MSB:CMD_LSB];
                next_en[c] = reg_wdata_i[EN_BIT];
                next_pin[c] = reg_wdata_i[PIN_MSB:PIN_LSB];
            end
            if (reg_wr_i && reg_addr_i == ch_base(c) + 16'h0001) begin
                next_high_time[c] = reg_wdata_i[TIME_MSB:0];
            end
            if (reg_wr_i && reg_addr_i == ch_base(c) + 16'h0002) begin
                next_low_time[c] = reg_wdata_i[TIME_MSB:0];
            end
            if (reg_addr_i == ch_base(c)) begin
                next_rdata = {7'h00, cmd[c], en[c], 2'h0, pin[c]};
            end
            if (reg_addr_i == ch_base(c) + 16'h0001) begin
                next_rdata = {4'h0, high_time[c]};
            end
            if (reg_addr_i == ch_base(c) + 16'h0002) begin
                next_rdata = {4'h0, low_time[c]};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < 2; c++) begin
                cmd[c] <= CMD_RESET;
                en[c] <= 1'b0;
                pin[c] <= PIN_RESET;
                high_time[c] <= TIME_RESET;
                low_time[c] <= TIME_RESET;
            end
            reg_rdata_o <= 16'h0000;
        end else begin
            for (int c = 0; c < 2; c++) begin
                cmd[c] <= next_cmd[c];
                en[c] <= next_en[c];
                pin[c] <= next_pin[c];
                high_time[c] <= next_high_time[c];
                low_time[c] <= next_low_time[c];
            end
            reg_rdata_o <= next_rdata;
        end
    end

    // ==========================================================
    // Tick prescaler
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic tick;

    always_comb begin
        next_acc = acc + ACC_STEP;
        tick = 1'b0;
        if (next_acc >= ACC_LIMIT) begin
            next_acc = next_acc - ACC_LIMIT;
            tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    // ==========================================================
    // Channel engines
    chan_state_t state [2];
    chan_state_t next_state [2];
    logic level [2];
    logic next_level [2];
    logic [11:0] cnt [2];
    logic [11:0] next_cnt [2];
    logic shot_done [2];
    logic next_shot_done [2];
    logic [7:0] next_pin_o;
    logic [7:0] next_pin_oe;

    always_comb begin
        next_pin_o = gp_pin_o;
        next_pin_oe = 8'h00;
        for (int c = 1; c >= 0; c--) begin
            next_state[c] = state[c];
            next_level[c] = level[c];
            next_cnt[c] = cnt[c];
            next_shot_done[c] = shot_done[c] && !ctrl_wr[c];
            if (!en[c]) begin
                next_state[c] = ST_HOLD;
            end else begin
                case (cmd[c])
                    CMD_LOW_A, CMD_LOW_B: begin
                        next_level[c] = 1'b0;
                        next_state[c] = ST_HOLD;
                    end
                    CMD_ONE_SHOT: begin
                        if (state[c] != ST_SHOT) begin
                            if (!shot_done[c]) begin
                                next_level[c] = !level[c];
                                next_cnt[c] = level[c] ? low_time[c] : high_time[c];
                                next_state[c] = ST_SHOT;
                            end else begin
                                next_state[c] = ST_HOLD;
                            end
                        end else if (tick) begin
                            if (cnt[c] <= 12'h001) begin
                                next_level[c] = !level[c];
                                next_state[c] = ST_HOLD;
                                next_shot_done[c] = 1'b1;
                            end else begin
                                next_cnt[c] = cnt[c] - 12'h001;
                            end
                        end
                    end
                    CMD_FREE_RUN: begin
                        if (state[c] != ST_RUN) begin
                            next_level[c] = 1'b1;
                            next_cnt[c] = high_time[c];
                            next_state[c] = ST_RUN;
                        end else if (tick) begin
                            if (cnt[c] <= 12'h001) begin
                                next_level[c] = !level[c];
                                next_cnt[c] = level[c] ? low_time[c] : high_time[c];
                            end else begin
                                next_cnt[c] = cnt[c] - 12'h001;
                            end
                        end
                    end
                    default: begin
                        next_state[c] = ST_HOLD;
                    end
                endcase
                next_pin_oe[pin[c]] = 1'b1;
                next_pin_o[pin[c]] = next_level[c];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < 2; c++) begin
                state[c] <= ST_HOLD;
                level[c] <= 1'b0;
                cnt[c] <= TIME_RESET;
                shot_done[c] <= 1'b0;
            end
            gp_pin_o <= 8'h00;
            gp_pin_oe_o <= 8'h00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                state[c] <= next_state[c];
                level[c] <= next_level[c];
                cnt[c] <= next_cnt[c];
                shot_done[c] <= next_shot_done[c];
            end
            gp_pin_o <= next_pin_o;
            gp_pin_oe_o <= next_pin_oe;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_idle_holds: assert property (
        (en[0] && cmd[0] == CMD_IDLE) |=> level[0] == $past(level[0]))
        else $error("idle command changed the level");

    a_force_low: assert property (
        (en[1] && (cmd[1] == CMD_LOW_A || cmd[1] == CMD_LOW_B))
        |=> !level[1] && state[1] == ST_HOLD)
        else $error("forced low command did not drive low");

    a_shot_start: assert property (
        (en[0] && cmd[0] == CMD_ONE_SHOT && state[0] == ST_HOLD && !shot_done[0])
        |=> state[0] == ST_SHOT && level[0] != $past(level[0]))
        else $error("one-shot did not start with inverted level");

    a_shot_return: assert property (
        (en[0] && cmd[0] == CMD_ONE_SHOT && state[0] == ST_SHOT && tick && cnt[0] == 12'h001)
        |=> state[0] == ST_HOLD && shot_done[0] && level[0] != $past(level[0]))
        else $error("one-shot did not end after its count");

    a_run_to_low: assert property (
        (en[0] && cmd[0] == CMD_FREE_RUN && state[0] == ST_RUN && level[0] && tick
            && cnt[0] == 12'h001)
        |=> !level[0] && cnt[0] == $past(low_time[0]))
        else $error("free run did not switch to low count");

    a_run_to_high: assert property (
        (en[1] && cmd[1] == CMD_FREE_RUN && state[1] == ST_RUN && !level[1] && tick
            && cnt[1] == 12'h001)
        |=> level[1] && cnt[1] == $past(high_time[1]))
        else $error("free run did not switch to high count");

    a_run_count: assert property (
        (en[0] && cmd[0] == CMD_FREE_RUN && state[0] == ST_RUN && tick && cnt[0] > 12'h001)
        |=> cnt[0] == $past(cnt[0]) - 12'h001 && $stable(level[0]))
        else $error("free run count did not step down");

    a_off_no_drive: assert property (
        (!en[0] && !en[1]) |=> gp_pin_oe_o == 8'h00)
        else $error("pin driven with both channels disabled");

    a_pin_route: assert property (
        en[0] |=> gp_pin_oe_o[$past(pin[0])] && gp_pin_o[$past(pin[0])] == level[0])
        else $error("channel output not on selected pin");

    a_tick_spacing: assert property (
        tick |=> !tick [*5])
        else $error("prescaler ticks too close together");

    c_one_shot: cover property (state[0] == ST_SHOT ##1 state[0] == ST_HOLD && shot_done[0]);
    c_run_toggle: cover property (state[1] == ST_RUN && level[1] ##1 !level[1]);
    c_both_on: cover property (en[0] && en[1] && gp_pin_oe_o != 8'h00);

endmodule : dual_pulse_out

// ==== sim/dual_pulse_out_tb_top.sv ====
// Self-checking bench for the dual pulse output block
`timescale 1ns/1ps
module dual_pulse_out_tb_top;
    import pulse_pkg::*;
    // ========================================
    // Signals and model state
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic [7:0] gp_pin_o;
    logic [7:0] gp_pin_oe_o;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] lfsr = 32'hf7b6;
    logic [15:0] exp_reg [0:5];
    int n;
    int hi_t;
    int lo_t;
    logic [2:0] p;
    logic [2:0] q;
    logic [2:0] cmds [0:1];

    always #20 clk_i = ~clk_i;

    dual_pulse_out i_dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .gp_pin_o(gp_pin_o),
        .gp_pin_oe_o(gp_pin_oe_o)
    );

    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    function automatic logic [15:0] ctl(input logic [2:0] c, input logic e, input logic [2:0] s);
        return {7'h00, c, e, 2'b00, s};
    endfunction : ctl

    task automatic bad(input string what);
        mismatches++;
        $display("mismatch at %0t: %s", $time, what);
    endtask : bad

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) bad($sformatf("register read %h expected %h", got, exp));
    endtask : chk_reg

    task automatic chk_pin(input logic [2:0] s, input logic oe, input logic lvl);
        samples_checked++;
        if (gp_pin_oe_o[s] !== oe || (oe && gp_pin_o[s] !== lvl)) bad("pin level or enable");
    endtask : chk_pin

    task automatic chk_width(input int cyc, input int ticks);
        samples_checked++;
        if (cyc < ((ticks - 1) * TICK_TIME_PS) / CLK_PERIOD_PS
            || cyc > ((ticks + 1) * TICK_TIME_PS) / CLK_PERIOD_PS + 1)
            bad($sformatf("width %0d cycles for %0d ticks", cyc, ticks));
    endtask : chk_width

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask : step

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step();
        reg_wr_i = 1'b0;
        step();
        if (a >= OFS_CH0_CONTROL && a <= OFS_CH1_LOW)
            exp_reg[a - OFS_CH0_CONTROL] = d & (((a - OFS_CH0_CONTROL) % 3 == 0) ? 16'h01e7 : 16'h0fff);
    endtask : reg_write

    task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
        reg_addr_i = a;
        step();
        chk_reg(reg_rdata_o, exp);
    endtask : reg_read

    task automatic wait_width(input logic [2:0] s, input logic lvl, output int cyc);
        cyc = 0;
        while (gp_pin_o[s] === lvl && cyc < 40000) begin
            step();
            cyc++;
        end
        if (cyc >= 40000) bad("pin stuck");
    endtask : wait_width

    task automatic hold_chk(input logic [2:0] s, input logic oe, input logic lvl, input int cyc);
        repeat (cyc) begin
            step();
            chk_pin(s, oe, lvl);
        end
    endtask : hold_chk

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    // ========================================
    // Watchdog
    initial begin
        #(40 * 90000);
        bad("watchdog expired");
        test_done();
    end

    // ========================================
    // Main sequence
    initial begin
        cmds[0] = CMD_LOW_A;
        cmds[1] = CMD_LOW_B;
        for (int i = 0; i < 6; i++) exp_reg[i] = (i % 3 == 0) ? 16'h0000 : 16'h0001;
        repeat (4) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        for (int i = 0; i < 6; i++) reg_read(OFS_CH0_CONTROL + 16'(i), exp_reg[i]);
        reg_read(16'h03de, 16'h0000);
        chk_reg({8'h00, gp_pin_oe_o}, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            if (i % 3 == 0) reg_write(OFS_CH0_CONTROL + 16'(i), lfsr[15:0] & 16'h0007);
            else reg_write(OFS_CH0_CONTROL + 16'(i), (lfsr[15:0] & 16'h0fff) | 16'h0001);
        end
        reg_write(16'h03d7, lfsr[15:0]);
        for (int i = 0; i < 6; i++) reg_read(OFS_CH0_CONTROL + 16'(i), exp_reg[i]);
        reg_write(OFS_CH0_CONTROL, 16'h0000);
        reg_write(OFS_CH1_CONTROL, 16'h0000);
        $display("test registers done");
        // free-run widths on a random pin
        lfsr = lfsr_next(lfsr);
        p = lfsr[2:0];
        hi_t = int'(lfsr[7:3]) + 2;
        lo_t = int'(lfsr[12:8]) + 2;
        reg_write(OFS_CH0_HIGH, 16'(hi_t));
        reg_write(OFS_CH0_LOW, 16'(lo_t));
        reg_write(OFS_CH0_CONTROL, ctl(CMD_FREE_RUN, 1'b1, p));
        step();
        chk_pin(p, 1'b1, 1'b1);
        wait_width(p, 1'b1, n);
        wait_width(p, 1'b0, n);
        chk_width(n, lo_t);
        wait_width(p, 1'b1, n);
        chk_width(n, hi_t);
        $display("test free run done");
        reg_write(OFS_CH0_HIGH, 16'h0fff);
        wait_width(p, 1'b0, n);
        reg_write(OFS_CH0_CONTROL, ctl(CMD_IDLE, 1'b1, p));
        hold_chk(p, 1'b1, 1'b1, 60);
        // one-shot after high gives a low pulse
        reg_write(OFS_CH0_CONTROL, ctl(CMD_ONE_SHOT, 1'b1, p));
        step();
        wait_width(p, 1'b0, n);
        chk_width(n, lo_t);
        hold_chk(p, 1'b1, 1'b1, 30);
        $display("test idle and one-shot low done");
        // both force-low codes, then a high one-shot
        reg_write(OFS_CH0_HIGH, 16'(hi_t));
        for (int k = 0; k < 2; k++) begin
            reg_write(OFS_CH0_CONTROL, ctl(CMD_FREE_RUN, 1'b1, p));
            step();
            reg_write(OFS_CH0_CONTROL, ctl(cmds[k], 1'b1, p));
            step();
            hold_chk(p, 1'b1, 1'b0, 80);
        end
        reg_write(OFS_CH0_CONTROL, ctl(CMD_ONE_SHOT, 1'b1, p));
        step();
        wait_width(p, 1'b1, n);
        chk_width(n, hi_t);
        hold_chk(p, 1'b1, 1'b0, 30);
        $display("test force low done");
        reg_write(OFS_CH0_CONTROL, ctl(CMD_FREE_RUN, 1'b0, p));
        step();
        repeat (40) begin
            step();
            chk_reg({8'h00, gp_pin_oe_o}, 16'h0000);
        end
        $display("test enable done");
        // second channel runs beside a forced first channel
        q = p ^ 3'h4;
        reg_write(OFS_CH0_CONTROL, ctl(CMD_LOW_A, 1'b1, p));
        reg_write(OFS_CH1_HIGH, 16'(lo_t));
        reg_write(OFS_CH1_LOW, 16'(hi_t));
        reg_write(OFS_CH1_CONTROL, ctl(CMD_FREE_RUN, 1'b1, q));
        step();
        wait_width(q, 1'b1, n);
        wait_width(q, 1'b0, n);
        chk_width(n, hi_t);
        wait_width(q, 1'b1, n);
        chk_width(n, lo_t);
        chk_pin(p, 1'b1, 1'b0);
        reg_write(OFS_CH1_CONTROL, ctl(CMD_LOW_B, 1'b1, q));
        hold_chk(q, 1'b1, 1'b0, 20);
        $display("test second channel done");
        test_done();
    end
endmodule : dual_pulse_out_tb_top
